/* File: core/fbsp_burst_step.sv */
// Purpose: next burst address from start bits and step count
// Assumes: only the two lowest address bits take part
// Notes: pure combinational
`timescale 1ns/100ps
`include "fbsp_defines.svh"
module fbsp_burst_step
    import fbsp_pkg::*;
(
    // burst state
    input wire logic [`FBSP_BURST_W-1:0] start_bits,
    input wire logic [`FBSP_BURST_W-1:0] step_cnt,
    input wire logic order_interleaved,
    // result
    output logic [`FBSP_BURST_W-1:0] next_bits
);
    // xor form for interleaved, wrap-around add for linear
    always_comb begin
        if (order_interleaved) begin
            next_bits = start_bits ^ step_cnt; // RULE_19
        end else begin
            next_bits = start_bits + step_cnt; // RULE_19
        end
    end
endmodule : fbsp_burst_step

/* File: core/fbsp_defines.svh */
// Purpose: named constants for the flow-through burst memory port
// Assumes: 32-bit word on four byte lanes, one parity bit per lane
// Notes: definitions only
`ifndef FBSP_DEFINES_SVH
`define FBSP_DEFINES_SVH
`define FBSP_LANES 4
`define FBSP_LANE_W 9
`define FBSP_ADDR_W 10
`define FBSP_DEPTH 1024
`define FBSP_BURST_W 2
`define FBSP_BURST_ONE 2'h1
`define FBSP_BURST_ZERO 2'h0
`define FBSP_ORDER_INTERLEAVED 1'b1
`endif

/* File: core/fbsp_pkg.sv */
// Purpose: types shared by the memory port files
// Assumes: constants come from fbsp_defines.svh
// Notes: none
`include "fbsp_defines.svh"
package fbsp_pkg;
    typedef logic [`FBSP_LANE_W-1:0] fbsp_lane_t;
    typedef fbsp_lane_t [`FBSP_LANES-1:0] fbsp_word_t;
    typedef struct packed {
        logic cq_n;
        logic sel1_n;
        logic sel2;
        logic sel3_n;
        logic we_n;
        logic adv;
        logic [`FBSP_LANES-1:0] bws_n;
        logic [`FBSP_ADDR_W-1:0] addr;
        fbsp_word_t din;
    } fbsp_ctl_t;
    typedef enum logic [1:0] {
        FBSP_IDLE = 2'b00,
        FBSP_READ = 2'b01,
        FBSP_WRITE = 2'b10
    } fbsp_op_t;
endpackage : fbsp_pkg

/* File: core/fbsp_port.sv */
// Purpose: flow-through burst static memory, synchronous device side
// Assumes: pins synchronised here; output enable and sleep seen late
// Notes: data pins come as in/out/enable, enable low while driving
// Notes on behaviour
// (RULE_01) advance high steps the burst counter
// (RULE_02) advance low loads a new address
// (RULE_03) master loads fresh address after deselect
// (RULE_04) edges act only with qualifier low
// (RULE_05) qualifier high freezes the cycle unchanged
// (RULE_06) select needs low, high, low
// (RULE_07) output enable low lets pins drive
// (RULE_08) float on write, deselect, first clock after
// (RULE_09) write data captured on rising edge
// (RULE_10) read shows location sampled one edge before
// (RULE_11) four eight-bit lanes form the word
// (RULE_12) parity bit follows its lane write select
// (RULE_13) sleep input keeps stored data, idles
// (RULE_14) order select high interleaved, low linear
// (RULE_15) order select held fixed while operating
// (RULE_16) per-lane write selects qualify writes
// (RULE_17) write starts with strobe and qualifier low
// (RULE_18) read needs selects, strobe high, load
// (RULE_19) burst varies two low bits only
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "fbsp_defines.svh"
module fbsp_port
    import fbsp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control pins
    input wire logic clock_qualifier_n,
    input wire logic select_first_n,
    input wire logic select_second,
    input wire logic select_third_n,
    input wire logic write_strobe_n,
    input wire logic advance_or_load,
    input wire logic [`FBSP_LANES-1:0] lane_write_select_n,
    input wire logic [`FBSP_ADDR_W-1:0] address,
    // static and asynchronous pins
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order,
    // data lanes: 8 data bits plus parity in bit 8 of each lane
    input wire logic [`FBSP_LANES*`FBSP_LANE_W-1:0] data_in,
    output logic [`FBSP_LANES*`FBSP_LANE_W-1:0] data_out,
    output logic data_oe_n,
    // status
    output logic sleeping
);
    // two-flop input synchronisers; stage one read only by stage two
    fbsp_ctl_t ctl_s1_reg;
    fbsp_ctl_t ctl_reg;
    logic [2:0] async_s1_reg;
    logic [2:0] async_reg;
    always_ff @(posedge core_clk) begin
        ctl_s1_reg <= '{clock_qualifier_n, select_first_n, select_second,
            select_third_n, write_strobe_n, advance_or_load,
            lane_write_select_n, address, data_in};
        ctl_reg <= ctl_s1_reg;
        async_s1_reg <= {output_enable_n, sleep_request, burst_order};
        async_reg <= async_s1_reg;
    end

    logic oe_n_q;
    logic sleep_q;
    logic order_q;
    assign oe_n_q = async_reg[2];
    assign sleep_q = async_reg[1];
    assign order_q = async_reg[0];

    // order select is latched once after reset; it must not move later
    logic order_reg;
    logic order_taken_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            order_reg <= `FBSP_ORDER_INTERLEAVED; // RULE_14
            order_taken_reg <= 1'b0;
        end else if (!order_taken_reg) begin
            order_reg <= order_q; // RULE_14 RULE_15
            order_taken_reg <= 1'b1;
        end
    end

    // qualified edge: qualifier low and not asleep
    logic edge_ok;
    logic selected;
    logic start_rd;
    logic start_wr;
    logic step;
    assign edge_ok = !ctl_reg.cq_n && !sleep_q; // RULE_04 RULE_05 RULE_13
    assign selected = !ctl_reg.sel1_n && ctl_reg.sel2
        && !ctl_reg.sel3_n; // RULE_06
    assign start_rd = edge_ok && selected && ctl_reg.we_n
        && !ctl_reg.adv; // RULE_18
    assign start_wr = edge_ok && selected && !ctl_reg.we_n
        && !ctl_reg.adv; // RULE_17
    assign step = edge_ok && ctl_reg.adv; // RULE_01

    // operation state; deselect leaves idle, qualifier high holds all
    fbsp_op_t op_reg;
    logic was_idle_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            op_reg <= FBSP_IDLE;
            was_idle_reg <= 1'b1;
        end else if (edge_ok) begin
            was_idle_reg <= (op_reg == FBSP_IDLE);
            if (start_rd) begin
                op_reg <= FBSP_READ;
            end else if (start_wr) begin
                op_reg <= FBSP_WRITE;
            end else if (!ctl_reg.adv) begin
                op_reg <= FBSP_IDLE; // RULE_06
            end
        end
    end

    // address register and burst counter
    logic [`FBSP_ADDR_W-1:0] base_reg;
    logic [`FBSP_BURST_W-1:0] cnt_reg;
    logic [`FBSP_BURST_W-1:0] cnt_next;
    logic [`FBSP_BURST_W-1:0] low_bits;
    assign cnt_next = cnt_reg + `FBSP_BURST_ONE;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            base_reg <= '0;
            cnt_reg <= `FBSP_BURST_ZERO;
        end else if (start_rd || start_wr) begin
            base_reg <= ctl_reg.addr; // RULE_02
            cnt_reg <= `FBSP_BURST_ZERO;
        end else if (step && op_reg != FBSP_IDLE) begin
            cnt_reg <= cnt_next; // RULE_01
        end
    end

    fbsp_burst_step u_step (
        .start_bits(base_reg[`FBSP_BURST_W-1:0]),
        .step_cnt(cnt_reg),
        .order_interleaved(order_reg),
        .next_bits(low_bits)
    );

    logic [`FBSP_ADDR_W-1:0] cur_addr;
    assign cur_addr = {base_reg[`FBSP_ADDR_W-1:`FBSP_BURST_W],
        low_bits}; // RULE_19

    // storage, one array per lane so that every array has one writer;
    // sleep blocks writes, content kept
    fbsp_word_t rd_word;
    logic wr_now;
    assign wr_now = edge_ok && op_reg == FBSP_WRITE; // RULE_09
    genvar gi;
    generate
        for (gi = 0; gi < `FBSP_LANES; gi++) begin : g_lane
            fbsp_lane_t lane_mem [`FBSP_DEPTH];
            fbsp_lane_t rd_lane;
            assign rd_lane = lane_mem[cur_addr];
            // parity bit rides in the lane, same select
            always_ff @(posedge core_clk) begin
                if (wr_now && !ctl_reg.bws_n[gi]) begin
                    lane_mem[cur_addr] <= ctl_reg.din[gi]; // RULE_12 RULE_16
                end
            end
        end
    endgenerate

    // lanes gathered back into one word, lane 0 lowest
    assign rd_word = {g_lane[3].rd_lane, g_lane[2].rd_lane,
        g_lane[1].rd_lane, g_lane[0].rd_lane}; // RULE_11

    // read data and driver enable, registered for clean outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data_out <= '0;
        end else if (edge_ok) begin
            data_out <= rd_word; // RULE_10 RULE_11
        end
    end

    logic drive_next;
    assign drive_next = op_reg == FBSP_READ && !was_idle_reg
        && !oe_n_q && !sleep_q; // RULE_07 RULE_08
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data_oe_n <= 1'b1;
            sleeping <= 1'b0;
        end else begin
            data_oe_n <= !drive_next; // RULE_08
            sleeping <= sleep_q; // RULE_13
        end
    end

    // checks
    sequence s_read_start;
        start_rd;
    endsequence
    chk_sel_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        (start_rd || start_wr) |-> selected) // RULE_06
        else $error("access started while deselected");
    chk_hold_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
        !edge_ok |=> $stable(op_reg) && $stable(cnt_reg)) // RULE_05
        else $error("state moved on an unqualified edge");
    chk_load_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_start |=> base_reg == $past(ctl_reg.addr)
        && cnt_reg == `FBSP_BURST_ZERO)
        // RULE_02
        else $error("address not loaded");
    chk_step_cnt: assert property (@(posedge core_clk) disable iff (!rst_n)
        (step && op_reg != FBSP_IDLE && !start_rd && !start_wr)
        |=> cnt_reg == $past(cnt_reg) + `FBSP_BURST_ONE) // RULE_01
        else $error("burst counter did not step");
    chk_write_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        op_reg == FBSP_WRITE |=> data_oe_n) // RULE_08
        else $error("driving during write");
    chk_idle_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        op_reg == FBSP_IDLE |=> data_oe_n) // RULE_08
        else $error("driving while deselected");
    chk_oe_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        oe_n_q |=> data_oe_n) // RULE_07
        else $error("driving with output enable high");
    chk_no_sleep_op: assert property (@(posedge core_clk) disable iff (!rst_n)
        sleep_q |-> !start_rd && !start_wr) // RULE_13
        else $error("access during sleep");
    chk_low_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        cur_addr[`FBSP_ADDR_W-1:`FBSP_BURST_W]
        == base_reg[`FBSP_ADDR_W-1:`FBSP_BURST_W]) // RULE_19
        else $error("burst touched upper address bits");

    // write start, the address phase of a write
    sequence s_write_start;
        start_wr;
    endsequence
    // a write load takes the address just like a read load
    chk_load_wr: assert property (@(posedge core_clk) // RULE_02
        disable iff (!rst_n) s_write_start |=> base_reg == $past(ctl_reg.addr))
        else $error("write address not loaded");
    chk_cnt_load: assert property (@(posedge core_clk) // RULE_02
        disable iff (!rst_n) (start_rd || start_wr)
        |=> cnt_reg == `FBSP_BURST_ZERO)
        else $error("burst counter not cleared on load");
    // the base only moves on a load, never on a beat
    chk_base_hold: assert property (@(posedge core_clk) // RULE_01
        disable iff (!rst_n) !start_rd && !start_wr |=> $stable(base_reg))
        else $error("base address moved without a load");
    // an advance with nothing in flight must not run the counter
    chk_step_idle: assert property (@(posedge core_clk) // RULE_01
        disable iff (!rst_n) step && op_reg == FBSP_IDLE |=> $stable(cnt_reg))
        else $error("counter stepped while idle");
    chk_rd_start: assert property (@(posedge core_clk) // RULE_18
        disable iff (!rst_n) s_read_start |=> op_reg == FBSP_READ)
        else $error("read not started");
    chk_wr_start: assert property (@(posedge core_clk) // RULE_17
        disable iff (!rst_n) s_write_start |=> op_reg == FBSP_WRITE)
        else $error("write not started");
    // any non-select pattern on a load drops back to idle
    chk_deselect_idle: assert property (@(posedge core_clk) // RULE_06
        disable iff (!rst_n) edge_ok && !selected && !ctl_reg.adv
        |=> op_reg == FBSP_IDLE)
        else $error("deselect did not go idle");
    // a frozen cycle keeps the read word on the pins
    chk_freeze_data: assert property (@(posedge core_clk) // RULE_05
        disable iff (!rst_n) !edge_ok |=> $stable(data_out))
        else $error("read data moved on an unqualified edge");
    chk_wr_hold: assert property (@(posedge core_clk) // RULE_05
        disable iff (!rst_n) !edge_ok && op_reg == FBSP_WRITE
        |=> op_reg == FBSP_WRITE)
        else $error("frozen write lost");
    // flow-through: the word comes from the address of the last edge
    chk_rd_data: assert property (@(posedge core_clk) // RULE_10
        disable iff (!rst_n) edge_ok |=> data_out == $past(rd_word))
        else $error("read word not from current address");
    chk_rd_drive: assert property (@(posedge core_clk) // RULE_07
        disable iff (!rst_n) op_reg == FBSP_READ && !was_idle_reg
        && !oe_n_q && !sleep_q |=> !data_oe_n)
        else $error("read data not driven");
    // first clock after idle stays off the bus to avoid contention
    chk_first_float: assert property (@(posedge core_clk) // RULE_08
        disable iff (!rst_n) was_idle_reg |=> data_oe_n)
        else $error("driving on first clock after idle");
    chk_wr_phase: assert property (@(posedge core_clk) // RULE_08
        disable iff (!rst_n) wr_now |=> data_oe_n)
        else $error("driving during write data phase");
    chk_rd_no_wr: assert property (@(posedge core_clk) // RULE_09
        disable iff (!rst_n) op_reg == FBSP_READ |-> !wr_now)
        else $error("array written during a read");
    // sleep: no writes, no state change, bus released
    chk_no_wr_sleep: assert property (@(posedge core_clk) // RULE_13
        disable iff (!rst_n) sleep_q |-> !wr_now)
        else $error("array written while asleep");
    chk_sleep_hold: assert property (@(posedge core_clk) // RULE_13
        disable iff (!rst_n) sleep_q |=> $stable(op_reg))
        else $error("state moved while asleep");
    chk_sleep_float: assert property (@(posedge core_clk) // RULE_13
        disable iff (!rst_n) sleep_q |=> data_oe_n)
        else $error("driving while asleep");
    chk_sleep_flag: assert property (@(posedge core_clk) // RULE_13
        disable iff (!rst_n) sleep_q |=> sleeping)
        else $error("sleep status not shown");
    // order is taken once; a later pin change must not reach it
    chk_order_fixed: assert property (@(posedge core_clk) // RULE_15
        disable iff (!rst_n) order_taken_reg |=> $stable(order_reg))
        else $error("burst order moved while operating");
    chk_order_taken: assert property (@(posedge core_clk) // RULE_14
        disable iff (!rst_n) order_taken_reg |=> order_taken_reg)
        else $error("burst order released without reset");
endmodule : fbsp_port

/* File: testbench/fbsp_mstr.sv */
// Purpose: bus master model for the memory port pins
// Assumes: one command per cycle, the port never stalls
// Notes: idle lanes carry the inverse of the last write word
`timescale 1ns/100ps
module fbsp_mstr
    import fbsp_pkg::*;
(
    // clock
    input wire logic core_clk,
    // device lane drive
    input wire fbsp_word_t dev_out,
    input wire logic dev_oe_n,
    // pins towards the port
    output fbsp_ctl_t pins,
    output fbsp_word_t lanes
);
    fbsp_word_t last = '0;
    fbsp_word_t pend = '0;
    logic [3:0] pend_bws = 4'hf;
    logic pend_v = 1'b0;
    logic wop = 1'b0;
    logic drv = 1'b0;
    // own write data wins; the port's float lags the pins by the sync
    assign lanes = (!dev_oe_n && !drv) ? dev_out : pins.din;
    initial pins = '1; // qualifier high until the first command
    // c = {qualifier_n, selects, strobe_n, advance}, held one cycle;
    // write data and lane selects follow in the next qualified cycle
    task cyc(input logic [5:0] c, input logic [3:0] bws,
            input logic [9:0] a, input fbsp_word_t d);
        pins <= {c, pend_v ? pend_bws : 4'hf, a,
            pend_v ? pend : ~last};
        drv <= pend_v;
        if (!c[5]) begin
            if (!c[0]) wop = c[4:2] == 3'b010 && !c[1];
            pend_v = wop;
            if (wop) begin
                pend = d;
                pend_bws = bws;
                last = d;
            end
        end
        @(posedge core_clk);
    endtask : cyc
endmodule : fbsp_mstr

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the burst memory port
// Assumes: the master model owns every synchronous pin
// Notes: expected words live in a shadow of the array
`timescale 1ns/100ps
module tb_top
    import fbsp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic oe_n = 1'b0;
    logic sleep_in = 1'b0;
    logic order = 1'b1;
    logic doe_n, slp;
    int n_errors = 0;
    int cmp_count = 0;
    fbsp_ctl_t pins;
    fbsp_word_t lanes, dout;
    fbsp_word_t mem_exp [0:1023];
    // the port, every synchronous pin from the master model
    fbsp_port fbsp_port_inst (.core_clk(core_clk), .rst_n(rst_n),
        .clock_qualifier_n(pins.cq_n), .select_first_n(pins.sel1_n),
        .select_second(pins.sel2), .select_third_n(pins.sel3_n),
        .write_strobe_n(pins.we_n), .advance_or_load(pins.adv),
        .lane_write_select_n(pins.bws_n), .address(pins.addr),
        .output_enable_n(oe_n), .sleep_request(sleep_in),
        .burst_order(order), .data_in(lanes), .data_out(dout),
        .data_oe_n(doe_n), .sleeping(slp));
    fbsp_mstr fbsp_mstr_inst (.core_clk(core_clk), .dev_out(dout),
        .dev_oe_n(doe_n), .pins(pins), .lanes(lanes));
    // 20 ns period
    initial forever #10 core_clk = ~core_clk;
    // compare tasks, one per kind of result
    task chk_w(input string nm, input fbsp_word_t e,
            input fbsp_word_t g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk_w
    task chk_b(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %b got %b", nm, e, g);
        end
    endtask : chk_b
    task end_sim;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // order select only moves under reset, the port latches it once
    task reset(input logic o);
        rst_n <= 1'b0;
        order <= o;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask : reset
    // write that lands; shadow follows the selected lanes only
    task wr(input logic [9:0] a, input logic [3:0] bws,
            input fbsp_word_t d);
        fbsp_mstr_inst.cyc(6'h08, bws, a, d);
        for (int i = 0; i < 4; i++)
            if (!bws[i]) mem_exp[a][i] = d[i];
    endtask : wr
    // repeated loads of one address give margin on the latency
    task rd(input logic [9:0] a);
        repeat (7) fbsp_mstr_inst.cyc(6'h0a, 4'hf, a, '0);
        chk_w("read data", mem_exp[a], dout);
        chk_b("drive enable", oe_n, doe_n);
    endtask : rd
    task wait_slp(input logic v);
        for (int i = 0; i < 8 && slp !== v; i++) @(posedge core_clk);
        chk_b("sleep flag", v, slp);
    endtask : wait_slp
    task t_write_read;
        wr(10'h005, 4'h0, {4{9'h1a5}});
        repeat (3) wr(10'h3ff, 4'h0, {9'h100, 9'h0ff, 9'h155, 9'h0aa});
        wr(10'h005, 4'ha, {4{9'h05a}});
        chk_b("write drive", 1'b1, doe_n);
        rd(10'h005);
        rd(10'h3ff);
        oe_n <= 1'b1;
        rd(10'h3ff);
        oe_n <= 1'b0;
    endtask : t_write_read
    // every select pattern but low-high-low must drop the write
    task t_deselect;
        repeat (5) fbsp_mstr_inst.cyc(6'h1a, 4'hf, 10'h005, '0);
        for (int s = 0; s < 8; s++)
            if (s != 2) begin
                fbsp_mstr_inst.cyc({1'b0, 3'(s), 2'b00}, 4'h0,
                    10'h005, '0);
                chk_b("idle drive", 1'b1, doe_n);
            end
        rd(10'h005);
    endtask : t_deselect
    // qualifier high holds the last read and drops a write
    task t_freeze;
        rd(10'h3ff);
        repeat (6) fbsp_mstr_inst.cyc(6'h28, 4'h0, 10'h005, '1);
        chk_w("held data", mem_exp[10'h3ff], dout);
        rd(10'h005);
    endtask : t_freeze
    task t_sleep;
        sleep_in <= 1'b1;
        wait_slp(1'b1);
        repeat (2) fbsp_mstr_inst.cyc(6'h08, 4'h0, 10'h005, '0);
        repeat (3) fbsp_mstr_inst.cyc(6'h1a, 4'hf, 10'h005, '0);
        sleep_in <= 1'b0;
        wait_slp(1'b0);
        rd(10'h005);
    endtask : t_sleep
    // burst from low bits 01; address pins on the beats are junk
    task t_burst(input logic o);
        reset(o);
        wr(10'h041, 4'h0, {4{9'h011}});
        for (int k = 1; k < 4; k++) begin
            fbsp_mstr_inst.cyc(6'h09, 4'h0, 10'h200, {4{9'(k)}});
            mem_exp[{8'h10, o ? 2'(k ^ 1) : 2'(k + 1)}] = {4{9'(k)}};
        end
        for (int k = 0; k < 4; k++) rd({8'h10, 2'(k)});
    endtask : t_burst
    initial begin
        t_burst(1'b1);
        t_write_read;
        t_deselect;
        t_freeze;
        t_sleep;
        t_burst(1'b0);
        end_sim;
    end
    // hang guard, far beyond the under two hundred cycles of the run
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        end_sim;
    end
endmodule : tb_top
